// ===== logic/clock_guard_top.sv
// system clock select, divider, power gating and transient guard
//
// Our own choice: the strobed register port.
`timescale 1ns/100ps

module clock_guard_top
   import clock_guard_pkg::*;
(
   input wire logic CLOCK,
   input wire logic RST_B,
   input wire logic [7:0] ADDR,
   input wire logic [7:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [7:0] RDATA,
   input wire logic SLOW_TICK,
   input wire logic FAST_TICK,
   input wire logic STOP_MODE,
   input wire logic IDLE_MODE,
   input wire logic FIRST_TRANSIENT,
   input wire logic SECOND_TRANSIENT,
   input wire logic PIN07_GPIO_OUT,
   input wire logic PIN07_GPIO_OE,
   output logic SLOW_OSC_KIND,
   output logic FAST_OSC_KIND,
   output logic CRYSTAL_PINS_EN,
   output logic SLOW_OSC_RUN,
   output logic FAST_OSC_RUN,
   output logic SYSTEM_ON_FAST,
   output logic SYSTEM_TICK,
   output logic PERIPH_CLOCK_EN,
   output logic [1:0] FIRST_SENSITIVITY,
   output logic [1:0] DETECTOR_ENABLE,
   output logic CPU_WAIT,
   output logic TRANSIENT_WAIT,
   output logic PIN07_OUT,
   output logic PIN07_OE
);

   clock_control_t clock_control;
   transient_control_t transient_detector_control;
   clock_control_t written_clock;
   clock_control_t next_clock_control;
   transient_control_t next_transient_control;

   // address decode
   logic hit_clock;
   logic hit_transient;
   logic hit_status;
   logic write_clock;
   logic write_transient;
   logic [7:0] next_rdata;
   logic [7:0] status_word;

   // write permissions for protected bits
   logic on_fast;
   logic on_slow;
   logic may_change_slow_kind;
   logic may_change_fast_kind;
   logic may_change_halt_fast;
   logic may_change_choice;

   // derived clock state
   logic [1:0] detector_enable;
   logic [1:0] detector_level;
   logic transient_seen;
   logic forced_slow;
   logic next_on_fast;
   logic next_slow_run;
   logic next_fast_run;
   logic next_periph_en;
   logic next_cpu_wait;
   logic next_pin_out;
   logic next_pin_oe;
   logic selected_tick;
   logic divided_tick;
   logic next_system_tick;
   logic [1:0] active_divider;
   logic next_crystal_pins;

   assign hit_clock = (ADDR == CLOCK_CONTROL_ADDR);
   assign hit_transient = (ADDR == TRANSIENT_CONTROL_ADDR);
   assign hit_status = (ADDR == CLOCK_STATUS_ADDR);
   assign write_clock = WR && hit_clock;
   assign write_transient = WR && hit_transient;
   assign written_clock = clock_control_t'(WDATA);

   // the permitting conditions look at the register as it stands before the write
   assign on_fast = clock_control.system_clock_choice;
   assign on_slow = !clock_control.system_clock_choice;
   assign may_change_slow_kind = on_fast;
   assign may_change_fast_kind = on_slow;
   assign may_change_halt_fast = on_slow;
   assign may_change_choice = !clock_control.halt_fast_osc;

   always_comb
   begin
      next_clock_control = clock_control;
      if (write_clock)
      begin
         // unprotected bits always land
         next_clock_control.halt_slow_osc_in_stop = written_clock.halt_slow_osc_in_stop;
         next_clock_control.gate_peripheral_clocks_idle =
            written_clock.gate_peripheral_clocks_idle;
         next_clock_control.system_clock_divider = written_clock.system_clock_divider;
         // protected bits land only when allowed
         if (may_change_slow_kind)
            next_clock_control.slow_osc_kind = written_clock.slow_osc_kind;
         if (may_change_fast_kind)
            next_clock_control.fast_osc_kind = written_clock.fast_osc_kind;
         if (may_change_halt_fast)
            next_clock_control.halt_fast_osc = written_clock.halt_fast_osc;
         if (may_change_choice)
            next_clock_control.system_clock_choice =
               written_clock.system_clock_choice;
      end
   end

   always_comb
   begin
      next_transient_control = transient_detector_control;
      if (write_transient)
      begin
         next_transient_control = transient_control_t'(WDATA);
         next_transient_control.reserved = 1'b0;
      end
   end

   always_ff @(posedge CLOCK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         clock_control <= clock_control_t'(CLOCK_CONTROL_RESET);
         transient_detector_control <= transient_control_t'(TRANSIENT_CONTROL_RESET);
      end
      else
      begin
         clock_control <= next_clock_control;
         transient_detector_control <= next_transient_control;
      end
   end

   // transient detectors
   assign detector_enable = {transient_detector_control.second_transient_detector_on,
                             transient_detector_control.first_transient_detector_on};
   assign detector_level = {SECOND_TRANSIENT, FIRST_TRANSIENT};

   transient_guard #(
      .COUNT(DETECTOR_COUNT)
   ) u_guard (
      .clk(CLOCK),
      .rst_b(RST_B),
      .enable(detector_enable),
      .raw_detect(detector_level),
      .detect(),
      .any_detect(transient_seen)
   );

   // system clock selection
   assign forced_slow = transient_detector_control.force_slow_on_transient
                        && transient_seen;
   assign next_on_fast = clock_control.system_clock_choice && !forced_slow;
   assign selected_tick = SYSTEM_ON_FAST ? FAST_TICK : SLOW_TICK;

   clock_divider u_divider (
      .clk(CLOCK),
      .rst_b(RST_B),
      .src_tick(selected_tick),
      .setting(clock_control.system_clock_divider),
      .tick_out(divided_tick),
      .active_setting(active_divider)
   );

   // oscillator and peripheral gating
   assign next_slow_run = !(clock_control.halt_slow_osc_in_stop && STOP_MODE);
   assign next_fast_run = !(clock_control.halt_fast_osc
                           && (!next_on_fast || IDLE_MODE));
   assign next_periph_en = !(clock_control.gate_peripheral_clocks_idle && IDLE_MODE)
                           && !STOP_MODE;
   assign next_system_tick = divided_tick && !STOP_MODE;
   assign next_crystal_pins = clock_control.slow_osc_kind
                              || clock_control.fast_osc_kind;

   // wait handling
   assign next_cpu_wait = transient_detector_control.cpu_wait_on_transient
                          && transient_seen;
   assign next_pin_out = transient_detector_control.wait_indication_to_pin ?
                         transient_seen : PIN07_GPIO_OUT;
   assign next_pin_oe = transient_detector_control.wait_indication_to_pin ?
                        1'b1 : PIN07_GPIO_OE;

   // read path
   assign status_word = {2'h0, active_divider, transient_seen, SYSTEM_ON_FAST,
                         FAST_OSC_RUN, SLOW_OSC_RUN};
   assign next_rdata = !RD ? READ_ZERO :
                       hit_clock ? clock_control :
                       hit_transient ? transient_detector_control :
                       hit_status ? status_word : READ_ZERO;

   always_ff @(posedge CLOCK or negedge RST_B)
   begin
      if (!RST_B)
         RDATA <= READ_ZERO;
      else
         RDATA <= next_rdata;
   end

   always_ff @(posedge CLOCK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         SLOW_OSC_KIND <= 1'b0;
         FAST_OSC_KIND <= 1'b0;
         CRYSTAL_PINS_EN <= 1'b0;
         SLOW_OSC_RUN <= 1'b1;
         FAST_OSC_RUN <= 1'b1;
         SYSTEM_ON_FAST <= 1'b0;
         SYSTEM_TICK <= 1'b0;
         PERIPH_CLOCK_EN <= 1'b1;
      end
      else
      begin
         SLOW_OSC_KIND <= clock_control.slow_osc_kind;
         FAST_OSC_KIND <= clock_control.fast_osc_kind;
         CRYSTAL_PINS_EN <= next_crystal_pins;
         SLOW_OSC_RUN <= next_slow_run;
         FAST_OSC_RUN <= next_fast_run;
         SYSTEM_ON_FAST <= next_on_fast;
         SYSTEM_TICK <= next_system_tick;
         PERIPH_CLOCK_EN <= next_periph_en;
      end
   end

   always_ff @(posedge CLOCK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         FIRST_SENSITIVITY <= 2'h0;
         DETECTOR_ENABLE <= 2'h0;
         CPU_WAIT <= 1'b0;
         TRANSIENT_WAIT <= 1'b0;
         PIN07_OUT <= 1'b0;
         PIN07_OE <= 1'b0;
      end
      else
      begin
         FIRST_SENSITIVITY <= transient_detector_control.first_detector_sensitivity;
         DETECTOR_ENABLE <= detector_enable;
         CPU_WAIT <= next_cpu_wait;
         TRANSIENT_WAIT <= transient_seen;
         PIN07_OUT <= next_pin_out;
         PIN07_OE <= next_pin_oe;
      end
   end

endmodule

// ===== include/clock_guard_pkg.sv
// shared constants and types for the system clock control block
package clock_guard_pkg;

   // register offsets
   localparam logic [7:0] CLOCK_CONTROL_ADDR = 8'hd8;
   localparam logic [7:0] TRANSIENT_CONTROL_ADDR = 8'he5;
   localparam logic [7:0] CLOCK_STATUS_ADDR = 8'hd9;

   // clock_control field positions
   localparam int SLOW_KIND_BIT = 7;
   localparam int FAST_KIND_BIT = 6;
   localparam int HALT_SLOW_BIT = 5;
   localparam int GATE_PERIPH_BIT = 4;
   localparam int HALT_FAST_BIT = 3;
   localparam int CLOCK_CHOICE_BIT = 2;
   localparam int DIVIDER_LSB = 0;

   // transient_detector_control field positions
   localparam int SECOND_ON_BIT = 7;
   localparam int FIRST_ON_BIT = 6;
   localparam int SENSITIVITY_LSB = 4;
   localparam int FORCE_SLOW_BIT = 3;
   localparam int CPU_WAIT_BIT = 2;
   localparam int WAIT_TO_PIN_BIT = 1;

   // reset values
   localparam logic [7:0] CLOCK_CONTROL_RESET = 8'h23;
   localparam logic [7:0] TRANSIENT_CONTROL_RESET = 8'h00;
   localparam logic [7:0] READ_ZERO = 8'h00;

   // divider settings and their counter masks
   localparam logic [1:0] DIV_BY_16 = 2'h0;
   localparam logic [1:0] DIV_BY_4 = 2'h1;
   localparam logic [1:0] DIV_BY_2 = 2'h2;
   localparam logic [1:0] DIV_BY_1 = 2'h3;
   localparam logic [3:0] MASK_BY_16 = 4'hf;
   localparam logic [3:0] MASK_BY_4 = 4'h3;
   localparam logic [3:0] MASK_BY_2 = 4'h1;
   localparam logic [3:0] MASK_BY_1 = 4'h0;
   localparam logic [3:0] DIVIDER_WRAP = 4'hf;

   // number of transient detectors
   localparam int DETECTOR_COUNT = 2;

   typedef struct packed {
      logic slow_osc_kind;
      logic fast_osc_kind;
      logic halt_slow_osc_in_stop;
      logic gate_peripheral_clocks_idle;
      logic halt_fast_osc;
      logic system_clock_choice;
      logic [1:0] system_clock_divider;
   } clock_control_t;

   typedef struct packed {
      logic second_transient_detector_on;
      logic first_transient_detector_on;
      logic [1:0] first_detector_sensitivity;
      logic force_slow_on_transient;
      logic cpu_wait_on_transient;
      logic wait_indication_to_pin;
      logic reserved;
   } transient_control_t;

endpackage

// ===== logic/clock_divider.sv
// system clock divider with deferred setting update
`timescale 1ns/100ps
module clock_divider
   import clock_guard_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic src_tick,
   input wire logic [1:0] setting,
   output logic tick_out,
   output logic [1:0] active_setting
);

   logic [3:0] count;
   logic [3:0] mask;
   logic wrap;
   logic hit;

   assign mask = (active_setting == DIV_BY_16) ? MASK_BY_16 :
                 (active_setting == DIV_BY_4) ? MASK_BY_4 :
                 (active_setting == DIV_BY_2) ? MASK_BY_2 : MASK_BY_1;
   assign wrap = src_tick && (count == DIVIDER_WRAP);
   assign hit = src_tick && ((count & mask) == mask);

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         count <= 4'h0;
         active_setting <= DIV_BY_1;
         tick_out <= 1'b0;
      end
      else
      begin
         if (src_tick)
            count <= count + 4'h1;
         // new setting taken only at the 16-tick boundary
         if (wrap)
            active_setting <= setting;
         tick_out <= hit;
      end
   end

endmodule

// ===== logic/transient_guard.sv
// fast-transient detector enables and combined detect level
`timescale 1ns/100ps
module transient_guard
   import clock_guard_pkg::*;
#(
   parameter int COUNT = DETECTOR_COUNT
)
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [COUNT-1:0] enable,
   input wire logic [COUNT-1:0] raw_detect,
   output logic [COUNT-1:0] detect,
   output logic any_detect
);

   genvar i;
   generate
      for (i = 0; i < COUNT; i++)
      begin : g_det
         // a disabled detector never reports
         always_ff @(posedge clk or negedge rst_b)
         begin
            if (!rst_b)
               detect[i] <= 1'b0;
            else
               detect[i] <= enable[i] & raw_detect[i];
         end
      end
   endgenerate

   assign any_detect = |detect;

endmodule

// ===== test/clock_guard_monitor.sv
// assertion checker for the system clock control block
`timescale 1ns/100ps
module clock_guard_monitor
   import clock_guard_pkg::*;
(
   input wire logic CLOCK,
   input wire logic RST_B,
   input wire logic [7:0] ADDR,
   input wire logic WR,
   input wire logic STOP_MODE,
   input wire logic IDLE_MODE,
   input wire logic PIN07_GPIO_OUT,
   input wire logic PIN07_GPIO_OE,
   input wire logic SLOW_OSC_KIND,
   input wire logic FAST_OSC_KIND,
   input wire logic SLOW_OSC_RUN,
   input wire logic FAST_OSC_RUN,
   input wire logic SYSTEM_ON_FAST,
   input wire logic SYSTEM_TICK,
   input wire logic PERIPH_CLOCK_EN,
   input wire logic CPU_WAIT,
   input wire logic TRANSIENT_WAIT,
   input wire logic PIN07_OUT,
   input wire logic PIN07_OE
);
   default clocking dc @(posedge CLOCK);
   endclocking
   default disable iff (!RST_B);
   property p_slow_halt;
      $past(RST_B) && !SLOW_OSC_RUN |-> $past(STOP_MODE);
   endproperty
   a_slow_halt: assert property (p_slow_halt) else $error("slow osc off outside stop");
   property p_periph_gate;
      $past(RST_B) && !PERIPH_CLOCK_EN |-> $past(STOP_MODE || IDLE_MODE);
   endproperty
   a_periph_gate: assert property (p_periph_gate) else $error("periph clock off when busy");
   property p_fast_halt;
      !FAST_OSC_RUN |-> !SYSTEM_ON_FAST || $past(IDLE_MODE);
   endproperty
   a_fast_halt: assert property (p_fast_halt) else $error("fast osc off while on fast");
   property p_tick_stop;
      $past(RST_B) && $past(STOP_MODE) |-> !SYSTEM_TICK;
   endproperty
   a_tick_stop: assert property (p_tick_stop) else $error("system tick in stop");
   property p_kind_write;
      $past(RST_B) && ($changed(SLOW_OSC_KIND) || $changed(FAST_OSC_KIND))
         |-> $past(WR, 2) && $past(ADDR, 2) == CLOCK_CONTROL_ADDR;
   endproperty
   a_kind_write: assert property (p_kind_write) else $error("osc kind moved unasked");
   property p_force_slow;
      $past(RST_B) && $fell(SYSTEM_ON_FAST)
         |-> TRANSIENT_WAIT || ($past(WR, 2) && $past(ADDR, 2) == CLOCK_CONTROL_ADDR);
   endproperty
   a_force_slow: assert property (p_force_slow) else $error("fast clock dropped unasked");
   property p_cpu_wait;
      CPU_WAIT |-> TRANSIENT_WAIT;
   endproperty
   a_cpu_wait: assert property (p_cpu_wait) else $error("cpu held with no transient");
   property p_pin_mux;
      $past(RST_B) && (PIN07_OUT != $past(PIN07_GPIO_OUT) || PIN07_OE != $past(PIN07_GPIO_OE))
         |-> PIN07_OE && PIN07_OUT == TRANSIENT_WAIT;
   endproperty
   a_pin_mux: assert property (p_pin_mux) else $error("pin neither gpio nor wait");
endmodule

bind clock_guard_top clock_guard_monitor u_mon (.CLOCK(CLOCK), .RST_B(RST_B), .ADDR(ADDR),
   .WR(WR), .STOP_MODE(STOP_MODE), .IDLE_MODE(IDLE_MODE), .PIN07_GPIO_OUT(PIN07_GPIO_OUT),
   .PIN07_GPIO_OE(PIN07_GPIO_OE), .SLOW_OSC_KIND(SLOW_OSC_KIND), .FAST_OSC_KIND(FAST_OSC_KIND),
   .SLOW_OSC_RUN(SLOW_OSC_RUN), .FAST_OSC_RUN(FAST_OSC_RUN), .SYSTEM_ON_FAST(SYSTEM_ON_FAST),
   .SYSTEM_TICK(SYSTEM_TICK), .PERIPH_CLOCK_EN(PERIPH_CLOCK_EN), .CPU_WAIT(CPU_WAIT),
   .TRANSIENT_WAIT(TRANSIENT_WAIT), .PIN07_OUT(PIN07_OUT), .PIN07_OE(PIN07_OE));

// ===== test/clock_guard_top_bench.sv
// self-checking bench for the system clock control block
`timescale 1ns/100ps
module clock_guard_top_bench
   import clock_guard_pkg::*;
;
   logic clock, rst_b, wr, rd, slow_tick, fast_tick, stop_mode, idle_mode;
   logic first_tr, second_tr, gpio_out, gpio_oe;
   logic [7:0] addr, wdata, rdata;
   logic slow_kind, fast_kind, xtal_en, slow_run, fast_run, on_fast, sys_tick, periph_en;
   logic cpu_wait, tr_wait, pin_out, pin_oe;
   logic [1:0] sens, det_en;
   logic [7:0] wv [6] = '{8'h87, 8'hcf, 8'h43, 8'h4b, 8'h4f, 8'h03};
   logic [7:0] ev [6] = '{8'h07, 8'h87, 8'h03, 8'h4b, 8'h4b, 8'h03};
   logic [7:0] dv [4] = '{8'h04, 8'h10, 8'h20, 8'h40};
   int n_fail, n_checks, cycles, ticks, i;

   clock_guard_top u_dut (.CLOCK(clock), .RST_B(rst_b), .ADDR(addr), .WDATA(wdata), .WR(wr),
      .RD(rd), .RDATA(rdata), .SLOW_TICK(slow_tick), .FAST_TICK(fast_tick),
      .STOP_MODE(stop_mode), .IDLE_MODE(idle_mode), .FIRST_TRANSIENT(first_tr),
      .SECOND_TRANSIENT(second_tr), .PIN07_GPIO_OUT(gpio_out), .PIN07_GPIO_OE(gpio_oe),
      .SLOW_OSC_KIND(slow_kind), .FAST_OSC_KIND(fast_kind), .CRYSTAL_PINS_EN(xtal_en),
      .SLOW_OSC_RUN(slow_run), .FAST_OSC_RUN(fast_run), .SYSTEM_ON_FAST(on_fast),
      .SYSTEM_TICK(sys_tick), .PERIPH_CLOCK_EN(periph_en), .FIRST_SENSITIVITY(sens),
      .DETECTOR_ENABLE(det_en), .CPU_WAIT(cpu_wait), .TRANSIENT_WAIT(tr_wait),
      .PIN07_OUT(pin_out), .PIN07_OE(pin_oe));

   initial
   begin
      clock = 0;
      forever #12.5 clock = ~clock;
   end

   // fast source ticks every other cycle, watchdog on run length
   always @(posedge clock)
   begin
      fast_tick <= ~fast_tick;
      cycles <= cycles + 1;
      if (cycles == 3000)
      begin
         n_fail = n_fail + 1;
         test_done;
      end
   end

   task test_done;
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
         n_fail++;
      end
   endtask

   task wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      wr <= 1;
      addr <= a;
      wdata <= d;
      @(posedge clock);
      wr <= 0;
   endtask

   task rd_reg(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clock);
      rd <= 1;
      addr <= a;
      @(posedge clock);
      rd <= 0;
      #1 chk(rdata, exp);
   endtask

   task wait_n(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask

   task tr_set(input logic f, input logic s);
      @(posedge clock);
      first_tr <= f;
      second_tr <= s;
      wait_n(3);
   endtask

   task mode_set(input logic s, input logic d);
      @(posedge clock);
      stop_mode <= s;
      idle_mode <= d;
      wait_n(3);
   endtask

   initial
   begin
      {rst_b, wr, rd, addr, wdata, fast_tick, stop_mode, idle_mode} = 0;
      {first_tr, second_tr, gpio_oe, n_fail, n_checks, cycles} = 0;
      slow_tick = 1;
      gpio_out = 1;
      repeat (10) @(posedge clock);
      rst_b <= 1;
      wait_n(1);
      chk({slow_run, fast_run, on_fast, periph_en}, 8'h0d);
      rd_reg(CLOCK_CONTROL_ADDR, 8'h23);
      rd_reg(TRANSIENT_CONTROL_ADDR, 8'h00);
      rd_reg(8'h00, 8'h00);
      for (i = 0; i < 6; i++)
      begin
         wr_reg(CLOCK_CONTROL_ADDR, wv[i]);
         rd_reg(CLOCK_CONTROL_ADDR, ev[i]);
         chk({slow_kind, fast_kind, xtal_en, on_fast, fast_run},
            {ev[i][7], ev[i][6], ev[i][7] | ev[i][6], ev[i][2], !(ev[i][3] && !ev[i][2])});
      end
      wr_reg(CLOCK_CONTROL_ADDR, 8'h33);
      mode_set(1, 0);
      chk({slow_run, periph_en, sys_tick}, 8'h00);
      mode_set(0, 1);
      chk({slow_run, periph_en}, 8'h02);
      wr_reg(CLOCK_CONTROL_ADDR, 8'h03);
      wait_n(2);
      chk(periph_en, 8'h01);
      mode_set(1, 0);
      chk({slow_run, periph_en}, 8'h02);
      mode_set(0, 0);
      for (i = 0; i < 4; i++)
      begin
         wr_reg(CLOCK_CONTROL_ADDR, {6'h00, i[1:0]});
         wait_n(20);
         rd_reg(CLOCK_STATUS_ADDR, {2'b00, i[1:0], 4'h3});
         ticks = 0;
         repeat (64) @(posedge clock) #1 ticks += (sys_tick === 1'b1);
         chk(ticks[7:0], dv[i]);
      end
      wr_reg(CLOCK_CONTROL_ADDR, 8'h07);
      wait_n(2);
      ticks = 0;
      repeat (64) @(posedge clock) #1 ticks += (sys_tick === 1'b1);
      chk(ticks[7:0], 8'h20);
      wr_reg(TRANSIENT_CONTROL_ADDR, 8'hff);
      rd_reg(TRANSIENT_CONTROL_ADDR, 8'hfe);
      chk({det_en, sens, on_fast}, 8'h1f);
      tr_set(1, 0);
      chk({tr_wait, cpu_wait, on_fast, pin_oe, pin_out}, 8'h1b);
      tr_set(0, 1);
      chk({tr_wait, cpu_wait, on_fast, pin_oe, pin_out}, 8'h1b);
      tr_set(0, 0);
      chk({tr_wait, cpu_wait, on_fast, pin_oe, pin_out}, 8'h06);
      wr_reg(TRANSIENT_CONTROL_ADDR, 8'h40);
      gpio_oe <= 1;
      gpio_out <= 0;
      tr_set(0, 1);
      chk({tr_wait, pin_oe, pin_out}, 8'h02);
      tr_set(1, 1);
      chk({tr_wait, cpu_wait, on_fast}, 8'h05);
      test_done;
   end
endmodule
